// ==== dmadtp_pkg.sv ====
// Constants, encodings and bus-cycle timelines shared by both ends.
package dmadtp_pkg;
  localparam int NCH = 4;
  localparam int AW = 24;
  localparam int DW = 16;
  // Register map of the controller.
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_MPTR = 8'h04;
  localparam logic [7:0] OFS_DPTR = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h40;
  localparam logic [7:0] OFS_STAT = 8'h44;
  localparam logic [7:0] OFS_HOLD = 8'h48;
  // Configuration word fields.
  localparam int CF_DT = 0;
  localparam int CF_PW = 2;
  localparam int CF_SZ = 3;
  localparam int CF_DIR = 5;
  localparam int CF_MC = 6;
  localparam int CF_DC = 8;
  localparam int CF_W = 10;
  localparam logic [CF_W-1:0] CFG_RST = 10'h000;
  localparam logic [AW-1:0] PTR_RST = 24'h000000;
  localparam logic [31:0] HOLD_RST = 32'h00000000;
  // Command and status bits.
  localparam int CMD_GO = 0;
  localparam int CMD_CH = 1;
  localparam int STS_BUSY = 0;
  localparam int STS_DONE = 1;
  localparam int STS_CH = 2;
  // Bus timing in controller clocks; one pclk is half a bus clock.
  localparam logic [3:0] MUX_END = 4'h3;
  localparam logic [3:0] NEVER = 4'hf;
  localparam int DEV_BIT = 23;
  localparam int E_DIV = 3;
  localparam int MEM_AW = 5;
  localparam int MEM_WORDS = 32;

  typedef enum logic [1:0] {DT_NATIVE, DT_ECLK, DT_ACK, DT_ACKRDY}
    dmadtp_devt_type;
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG, SZ_RSVD}
    dmadtp_size_type;
  typedef enum logic [1:0] {CNT_HOLD, CNT_UP, CNT_DOWN, CNT_RSVD}
    dmadtp_cnt_type;
  typedef enum logic [1:0] {CK_NAT, CK_ECLK, CK_S_M2D, CK_S_D2M}
    dmadtp_kind_type;
  typedef struct packed {
    logic [3:0] ack_on;
    logic [3:0] ds_on;
    logic [3:0] samp;
    logic [3:0] dtc_at;
    logic [3:0] ds_off;
    logic [3:0] last;
  } dmadtp_tl_type;

  // Cycle positions of strobes; samp is where the cycle waits.
  function automatic dmadtp_tl_type timeline(input dmadtp_kind_type k);
    dmadtp_tl_type t;
    unique case (k)
      CK_NAT: t = '{NEVER, 4'h3, 4'h4, NEVER, 4'h6, 4'h7};
      CK_ECLK: t = '{4'h1, 4'h3, 4'h4, NEVER, 4'h6, 4'h7};
      CK_S_M2D: t = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h6, 4'h7};
      CK_S_D2M: t = '{4'h1, 4'h3, 4'h6, 4'h8, 4'h8, 4'h9};
    endcase
    return t;
  endfunction : timeline

  function automatic logic [3:0] bytes(input dmadtp_size_type s);
    return (s == SZ_LONG) ? 4'h4 : (s == SZ_WORD) ? 4'h2 : 4'h1;
  endfunction : bytes

  function automatic logic [AW-1:0] step(input logic [AW-1:0] p,
                                         input dmadtp_cnt_type c,
                                         input logic [3:0] amt);
    if (c == CNT_UP) return p + AW'(amt);
    if (c == CNT_DOWN) return p - AW'(amt);
    return p;
  endfunction : step
endpackage : dmadtp_pkg

// ==== dmadtp_if.sv ====
// Shared system bus between the controller and the memory/peripheral end.
`timescale 1ns/1ns
interface dmadtp_if;
  logic        bus_req;
  logic        bus_grant;
  logic        own_n;
  logic        own_oe;
  logic        ctl_oe;
  logic        as_n;
  logic        uds_n;
  logic        lds_n;
  logic        rw;
  logic [7:1]  addr_lo;
  logic [15:0] ctrl_ad;
  logic        ctrl_ad_oe;
  logic [15:0] sys_ad;
  logic        sys_ad_oe;
  logic [15:0] muxed_addr_data_lines;
  logic        data_ack_n;
  logic [3:0]  grant_strobe_n;
  logic        transfer_complete_strobe_n;
  logic        buffer_direction;
  logic        buffer_enable_strobe_n;
  logic [3:0]  peripheral_control_line;

  // Undriven lines read as pulled high.
  assign muxed_addr_data_lines = ctrl_ad_oe ? ctrl_ad :
                                 sys_ad_oe ? sys_ad : 16'hffff;

  modport ctrl (
    output bus_req, own_n, own_oe, ctl_oe, as_n, uds_n, lds_n, rw,
    output addr_lo, ctrl_ad, ctrl_ad_oe, grant_strobe_n,
    output transfer_complete_strobe_n, buffer_direction,
    output buffer_enable_strobe_n,
    input  bus_grant, muxed_addr_data_lines, data_ack_n,
    input  peripheral_control_line, sys_ad_oe
  );
  modport sys (
    input  bus_req, own_n, own_oe, ctl_oe, as_n, uds_n, lds_n, rw,
    input  addr_lo, ctrl_ad_oe, grant_strobe_n,
    input  transfer_complete_strobe_n, muxed_addr_data_lines,
    output bus_grant, sys_ad, sys_ad_oe, data_ack_n,
    output peripheral_control_line
  );
endinterface : dmadtp_if

// ==== dmadtp_ctrl.sv ====
// Four-channel DMA transfer engine with per-channel device protocols.
// Summary of operation
// (R1) Device type field selects the four protocols; acknowledge-with-ready runs the same as acknowledge-only.
// (R2) Dual mode stages parts through holding register.
// (R3) Native device uses strobe and data-acknowledge handshake.
// (R4) Enable-clocked channel takes its control line as input.
// (R5) Enable-clocked bus uses grant strobe as valid-address.
// (R6) Enable-clocked read captured on enable falling edge.
// (R7) Long on byte port: four parts, pointer steps eight.
// (R8) Memory side always sequenced as 16-bit words.
// (R9) Port width bit sizes peripheral only; zero is byte.
// (R10) Long to byte device: upper word first.
// (R11) Pointers step to next operand at operand end.
// (R12) Single mode: grant strobe selects, one cycle.
// (R13) Acknowledge-only: grant, then complete strobe after acknowledge.
// (R14) Strobes held half clock after complete strobe.
// (R15) Single device-to-memory: strobes one clock after grant.
// (R16) Master indicator leads and trails other controls.
// (R17) Buffer direction and enable negated in single mode.
// (R18) Single cycles: four clocks out, five in.
// (R19) Byte port single mode asserts one data strobe.
// (R20) Upper address on muxed lines first 1.5 clocks.
// (R21) Software matches port and operand size in single.
// (R22) Channel configuration and holding state kept per channel.
`timescale 1ns/1ns
module dmadtp_ctrl (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // System bus
  dmadtp_if.ctrl           bus
);
  typedef enum logic [2:0] {S_IDLE, S_REQ, S_OWN, S_CYC, S_GAP, S_REL}
    dmadtp_st_type;

  logic [dmadtp_pkg::CF_W-1:0] cfg_ff [dmadtp_pkg::NCH];
  logic [dmadtp_pkg::AW-1:0]   mptr_ff [dmadtp_pkg::NCH];
  logic [dmadtp_pkg::AW-1:0]   dptr_ff [dmadtp_pkg::NCH];
  logic [31:0]                 hold_ff [dmadtp_pkg::NCH];
  dmadtp_st_type               st_ff;
  logic [1:0]                  chan_ff;
  logic                        done_ff;
  logic                        mp_ff;
  logic                        dp_ff;
  logic                        dev_ff;
  logic [3:0]                  cyc_ff;
  logic [3:0]                  pcl_q_ff;

  logic [dmadtp_pkg::CF_W-1:0] cfg;
  dmadtp_pkg::dmadtp_devt_type dt;
  dmadtp_pkg::dmadtp_size_type sz;
  dmadtp_pkg::dmadtp_cnt_type  mc;
  dmadtp_pkg::dmadtp_cnt_type  dc;
  dmadtp_pkg::dmadtp_kind_type kind;
  dmadtp_pkg::dmadtp_tl_type   tl;
  logic                        pw;
  logic                        d2m;
  logic                        single;
  logic                        klast;
  logic                        mlast;
  logic                        rd;
  logic                        devb;
  logic                        bytea;
  logic                        incyc;
  logic                        ds;
  logic                        go;
  logic                        efall;
  logic                        capt;
  logic                        fin;
  logic                        wr;
  logic                        lock;
  logic                        hit;
  logic [1:0]                  rch;
  logic [2:0]                  goff;
  logic [dmadtp_pkg::AW-1:0]   addr;
  logic [15:0]                 slot;
  logic [15:0]                 nxt_slot;
  logic [15:0]                 wdat;
  logic [7:0]                  rbyte;
  logic [3:0]                  damt;
  logic [3:0]                  nbytes;

  // Decode of the active channel's configuration.
  assign cfg = cfg_ff[chan_ff];
  assign dt = dmadtp_pkg::dmadtp_devt_type'(cfg[dmadtp_pkg::CF_DT +: 2]);
  assign sz = dmadtp_pkg::dmadtp_size_type'(cfg[dmadtp_pkg::CF_SZ +: 2]);
  assign mc = dmadtp_pkg::dmadtp_cnt_type'(cfg[dmadtp_pkg::CF_MC +: 2]);
  assign dc = dmadtp_pkg::dmadtp_cnt_type'(cfg[dmadtp_pkg::CF_DC +: 2]);
  assign pw = cfg[dmadtp_pkg::CF_PW]; // [R9]
  assign d2m = cfg[dmadtp_pkg::CF_DIR];
  assign single = (dt == dmadtp_pkg::DT_ACK) ||
                  (dt == dmadtp_pkg::DT_ACKRDY); // [R1]
  assign klast = !pw && (sz != dmadtp_pkg::SZ_BYTE); // [R7] [R9]
  assign mlast = (sz == dmadtp_pkg::SZ_LONG); // [R8]
  assign devb = dev_ff && !single && !pw;

  always_comb begin
    if (single)
      kind = d2m ? dmadtp_pkg::CK_S_D2M : dmadtp_pkg::CK_S_M2D; // [R12]
    else if (dev_ff && dt == dmadtp_pkg::DT_ECLK)
      kind = dmadtp_pkg::CK_ECLK; // [R1] [R5]
    else
      kind = dmadtp_pkg::CK_NAT; // [R3]
  end
  assign tl = dmadtp_pkg::timeline(kind);

  // Part addresses rise by two from the pointer.
  assign goff = klast ? {mp_ff, dp_ff, 1'b0} : {1'b0, mp_ff, 1'b0}; // [R7]
  assign addr = (dev_ff && !single) ? dptr_ff[chan_ff] + 24'(goff) :
                mptr_ff[chan_ff] + 24'({mp_ff, 1'b0}); // [R8]
  assign rd = single ? !d2m : (dev_ff == d2m); // [R2]
  assign bytea = devb || (sz == dmadtp_pkg::SZ_BYTE);
  assign slot = (mlast && !mp_ff) ? hold_ff[chan_ff][31:16]
                                  : hold_ff[chan_ff][15:0]; // [R10]

  always_comb begin
    if (devb)
      wdat = {8'h00, (klast && !dp_ff) ? slot[15:8] : slot[7:0]}; // [R10]
    else if (bytea)
      wdat = {slot[7:0], slot[7:0]};
    else
      wdat = slot;
  end

  assign rbyte = (devb || addr[0]) ? bus.muxed_addr_data_lines[7:0]
                                   : bus.muxed_addr_data_lines[15:8];
  always_comb begin
    nxt_slot = slot;
    if (devb && klast) begin
      if (dp_ff) nxt_slot[7:0] = rbyte;
      else nxt_slot[15:8] = rbyte;
    end else if (bytea) begin
      nxt_slot[7:0] = rbyte;
    end else begin
      nxt_slot = bus.muxed_addr_data_lines;
    end
  end

  // The enable clock comes from same-clock logic, so no synchroniser.
  assign efall = pcl_q_ff[chan_ff] && !bus.peripheral_control_line[chan_ff];
  assign go = (cyc_ff != tl.samp) ||
              ((kind == dmadtp_pkg::CK_ECLK) ? efall
                                             : !bus.data_ack_n); // [R3] [R6]
  assign incyc = (st_ff == S_CYC);
  assign capt = incyc && (cyc_ff == tl.samp) && go && rd && !single; // [R2]

  // Operand completion seen at the gap after each bus cycle.
  always_comb begin
    fin = 1'b0;
    if (single) fin = 1'b1; // [R12]
    else if (!dev_ff) fin = d2m && (mp_ff == mlast);
    else fin = !d2m && (dp_ff == klast) && (mp_ff == mlast);
  end

  always_ff @(posedge pclk or negedge presetn) begin : state_reg
    if (!presetn) begin
      st_ff <= S_IDLE;
      chan_ff <= 2'h0;
      cyc_ff <= 4'h0;
    end else begin
      unique case (st_ff)
        S_IDLE: if (wr && paddr == dmadtp_pkg::OFS_CMD &&
                    pwdata[dmadtp_pkg::CMD_GO]) begin
          st_ff <= S_REQ;
          chan_ff <= pwdata[dmadtp_pkg::CMD_CH +: 2];
        end
        S_REQ: if (bus.bus_grant) st_ff <= S_OWN; // [R3]
        S_OWN: begin
          st_ff <= S_CYC; // [R16]
          cyc_ff <= 4'h0;
        end
        S_CYC: if (go) begin
          if (cyc_ff == tl.last) st_ff <= S_GAP; // [R18]
          else cyc_ff <= cyc_ff + 4'h1;
        end
        S_GAP: begin
          st_ff <= fin ? S_REL : S_CYC;
          cyc_ff <= 4'h0;
        end
        S_REL: st_ff <= S_IDLE; // [R16]
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin : part_seq
    if (!presetn) begin
      mp_ff <= 1'b0;
      dp_ff <= 1'b0;
      dev_ff <= 1'b0;
    end else if (st_ff == S_OWN) begin
      mp_ff <= 1'b0;
      dp_ff <= 1'b0;
      dev_ff <= d2m && !single; // [R2]
    end else if (st_ff == S_GAP && !fin) begin
      if (!dev_ff) begin
        dev_ff <= 1'b1;
        dp_ff <= 1'b0;
        if (d2m) mp_ff <= 1'b1;
      end else if (dp_ff != klast) begin
        dp_ff <= 1'b1; // [R7]
      end else begin
        dev_ff <= 1'b0; // [R10]
        if (!d2m) mp_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin : hold_regs
    if (!presetn) begin
      for (int i = 0; i < dmadtp_pkg::NCH; i++)
        hold_ff[i] <= dmadtp_pkg::HOLD_RST;
    end else if (capt) begin
      if (mlast && !mp_ff) hold_ff[chan_ff][31:16] <= nxt_slot; // [R22]
      else hold_ff[chan_ff][15:0] <= nxt_slot; // [R2]
    end
  end

  assign wr = psel && penable && pwrite;
  assign rch = paddr[5:4];
  assign lock = (st_ff != S_IDLE) && (rch == chan_ff);
  assign nbytes = dmadtp_pkg::bytes(sz);
  assign damt = pw ? nbytes : {nbytes[2:0], 1'b0}; // [R7]

  always_ff @(posedge pclk or negedge presetn) begin : chan_regs
    if (!presetn) begin
      for (int i = 0; i < dmadtp_pkg::NCH; i++) begin
        cfg_ff[i] <= dmadtp_pkg::CFG_RST;
        mptr_ff[i] <= dmadtp_pkg::PTR_RST;
        dptr_ff[i] <= dmadtp_pkg::PTR_RST;
      end
    end else if (st_ff == S_GAP && fin) begin
      mptr_ff[chan_ff] <= dmadtp_pkg::step(mptr_ff[chan_ff], mc,
                                           dmadtp_pkg::bytes(sz)); // [R11]
      if (!single)
        dptr_ff[chan_ff] <= dmadtp_pkg::step(dptr_ff[chan_ff], dc,
                                             damt); // [R11]
    end else if (wr && !paddr[7] && !paddr[6] && !lock) begin
      // The active channel is locked so a transfer never sees a torn setup.
      if (paddr[3:0] == dmadtp_pkg::OFS_CFG[3:0])
        cfg_ff[rch] <= pwdata[dmadtp_pkg::CF_W-1:0]; // [R22]
      if (paddr[3:0] == dmadtp_pkg::OFS_MPTR[3:0])
        mptr_ff[rch] <= pwdata[dmadtp_pkg::AW-1:0];
      if (paddr[3:0] == dmadtp_pkg::OFS_DPTR[3:0])
        dptr_ff[rch] <= pwdata[dmadtp_pkg::AW-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin : done_flag
    if (!presetn) done_ff <= 1'b0;
    else if (st_ff == S_REL) done_ff <= 1'b1;
    else if (st_ff == S_IDLE && wr && paddr == dmadtp_pkg::OFS_CMD &&
             pwdata[dmadtp_pkg::CMD_GO]) done_ff <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin : pcl_edge
    if (!presetn) pcl_q_ff <= 4'h0;
    else pcl_q_ff <= bus.peripheral_control_line; // [R4]
  end

  // APB answers in the access cycle with no wait states.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  always_comb begin
    prdata = 32'h00000000;
    hit = 1'b1;
    if (!paddr[7] && !paddr[6]) begin
      if (paddr[3:0] == dmadtp_pkg::OFS_CFG[3:0])
        prdata = 32'(cfg_ff[rch]);
      else if (paddr[3:0] == dmadtp_pkg::OFS_MPTR[3:0])
        prdata = 32'(mptr_ff[rch]);
      else if (paddr[3:0] == dmadtp_pkg::OFS_DPTR[3:0])
        prdata = 32'(dptr_ff[rch]);
      else hit = 1'b0;
    end else if (paddr == dmadtp_pkg::OFS_STAT) begin
      prdata[dmadtp_pkg::STS_BUSY] = (st_ff != S_IDLE);
      prdata[dmadtp_pkg::STS_DONE] = done_ff;
      prdata[dmadtp_pkg::STS_CH +: 2] = chan_ff;
    end else if (paddr == dmadtp_pkg::OFS_HOLD) begin
      prdata = hold_ff[chan_ff];
    end else if (paddr != dmadtp_pkg::OFS_CMD) begin
      hit = 1'b0;
    end
  end

  // Bus outputs.
  assign bus.bus_req = (st_ff != S_IDLE) && (st_ff != S_REL);
  assign bus.own_oe = (st_ff != S_IDLE) && (st_ff != S_REQ); // [R16]
  assign bus.own_n = !bus.own_oe;
  assign bus.ctl_oe = incyc || (st_ff == S_GAP); // [R16]
  assign bus.as_n = !incyc;
  assign ds = incyc && (cyc_ff >= tl.ds_on) &&
              (cyc_ff <= tl.ds_off); // [R14] [R15]
  assign bus.uds_n = !(ds && !devb && (!bytea || !addr[0])); // [R19]
  assign bus.lds_n = !(ds && (devb || !bytea || addr[0])); // [R19]
  assign bus.rw = rd;
  assign bus.addr_lo = addr[7:1];
  assign bus.ctrl_ad_oe = incyc && ((cyc_ff < dmadtp_pkg::MUX_END) ||
                                    (!rd && !single)); // [R20]
  assign bus.ctrl_ad = (cyc_ff < dmadtp_pkg::MUX_END) ? addr[23:8] : wdat;
  always_comb begin
    for (int i = 0; i < dmadtp_pkg::NCH; i++)
      bus.grant_strobe_n[i] = !(incyc && (2'(i) == chan_ff) &&
                                (cyc_ff >= tl.ack_on)); // [R5] [R13]
  end
  assign bus.transfer_complete_strobe_n = !(incyc &&
                                            (cyc_ff == tl.dtc_at)); // [R13]
  assign bus.buffer_direction = incyc && !single && !rd; // [R17]
  assign bus.buffer_enable_strobe_n = !(incyc && !single &&
                                        (cyc_ff >= tl.ds_on)); // [R17]
endmodule : dmadtp_ctrl

// ==== dmadtp_sys.sv ====
// Memory and peripheral end of the system bus, answering the controller.
`timescale 1ns/1ns
module dmadtp_sys (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // System bus
  dmadtp_if.sys            bus,
  // Peripheral user side
  input  wire logic [15:0] dev_rd_data,
  output logic      [15:0] dev_wr_data,
  output logic             dev_wr_stb,
  // Memory inspection
  input  wire logic [4:0]  peek_addr,
  output logic      [15:0] peek_data
);
  logic [15:0]             mem_ff [dmadtp_pkg::MEM_WORDS];
  logic [dmadtp_pkg::E_DIV-1:0] ediv_ff;
  logic [15:0]             hi_ff;
  logic [15:0]             rdat_ff;
  logic [15:0]             dlat_ff;
  logic [15:0]             dwr_ff;
  logic [15:0]             peek_ff;
  logic                    as_q_ff;
  logic                    ds_q_ff;
  logic                    gr_q_ff;
  logic                    e_q_ff;
  logic                    dack_ff;
  logic                    stb_ff;
  logic                    bg_ff;

  logic [15:0] hi;
  logic [4:0]  idx;
  logic        devr;
  logic        gr;
  logic        ds;
  logic        e;
  logic        memacc;
  logic        natdev;
  logic        wpulse;

  // Upper address is only on the lines early, so it is latched.
  assign hi = (!bus.as_n && as_q_ff) ? bus.muxed_addr_data_lines
                                     : hi_ff; // [R20]
  // The latched copy is used so the data lines never feed back on themselves.
  assign devr = hi_ff[dmadtp_pkg::DEV_BIT-8];
  assign idx = bus.addr_lo[dmadtp_pkg::MEM_AW:1];
  assign gr = !(&bus.grant_strobe_n);
  assign ds = !bus.uds_n || !bus.lds_n;
  assign e = ediv_ff[dmadtp_pkg::E_DIV-1];
  assign memacc = !bus.as_n && ds && !devr;
  assign natdev = !bus.as_n && ds && devr && !gr;
  assign wpulse = (natdev && !bus.rw && !ds_q_ff) ||
                  (devr && gr && !bus.rw && ds_q_ff && e_q_ff && !e) || // [R5]
                  (gr && bus.rw && !bus.transfer_complete_strobe_n); // [R14]

  always_ff @(posedge pclk or negedge presetn) begin : edges
    if (!presetn) begin
      as_q_ff <= 1'b1;
      ds_q_ff <= 1'b0;
      gr_q_ff <= 1'b0;
      e_q_ff <= 1'b0;
      ediv_ff <= '0;
      hi_ff <= 16'h0000;
      bg_ff <= 1'b0;
    end else begin
      as_q_ff <= bus.as_n;
      ds_q_ff <= ds;
      gr_q_ff <= gr;
      e_q_ff <= e;
      ediv_ff <= ediv_ff + 1'b1; // [R4]
      hi_ff <= hi;
      bg_ff <= bus.bus_req;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin : answer
    if (!presetn) begin
      dack_ff <= 1'b0;
      rdat_ff <= 16'h0000;
      dlat_ff <= 16'h0000;
    end else begin
      dack_ff <= memacc || natdev; // [R3]
      rdat_ff <= devr ? dev_rd_data : mem_ff[idx];
      // The device value is held from grant until the late capture.
      if (gr && !gr_q_ff) dlat_ff <= dev_rd_data; // [R6] [R15]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin : memory
    if (!presetn) begin
      for (int i = 0; i < dmadtp_pkg::MEM_WORDS; i++)
        mem_ff[i] <= 16'h0000;
    end else if (memacc && !bus.rw) begin
      if (!bus.uds_n) mem_ff[idx][15:8] <= bus.muxed_addr_data_lines[15:8];
      if (!bus.lds_n) mem_ff[idx][7:0] <= bus.muxed_addr_data_lines[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin : device
    if (!presetn) begin
      dwr_ff <= 16'h0000;
      stb_ff <= 1'b0;
      peek_ff <= 16'h0000;
    end else begin
      if (wpulse) dwr_ff <= bus.muxed_addr_data_lines;
      stb_ff <= wpulse;
      peek_ff <= mem_ff[peek_addr];
    end
  end

  assign bus.bus_grant = bg_ff;
  assign bus.data_ack_n = !dack_ff;
  assign bus.peripheral_control_line = {dmadtp_pkg::NCH{e}}; // [R4]
  assign bus.sys_ad_oe = !bus.ctrl_ad_oe &&
                         ((dack_ff && bus.rw) || (gr && bus.rw && devr) ||
                          (gr && !bus.rw && !devr)); // [R15]
  assign bus.sys_ad = (dack_ff && bus.rw) ? rdat_ff : dlat_ff;
  assign dev_wr_data = dwr_ff;
  assign dev_wr_stb = stb_ff;
  assign peek_data = peek_ff;
endmodule : dmadtp_sys

// ==== dmadtp_props.sv ====
// Timing checks on the shared system bus between the two ends.
`timescale 1ns/1ns
module dmadtp_props (
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // Bus signals
  input wire logic       own_oe,
  input wire logic       ctl_oe,
  input wire logic       as_n,
  input wire logic       uds_n,
  input wire logic       lds_n,
  input wire logic       rw,
  input wire logic       ctrl_ad_oe,
  input wire logic [3:0] grant_strobe_n,
  input wire logic       transfer_complete_strobe_n,
  input wire logic       buffer_direction,
  input wire logic       buffer_enable_strobe_n
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire gnt = grant_strobe_n != 4'hf;
  wire tc = !transfer_complete_strobe_n;
  wire ds = !(uds_n && lds_n);

  own_lead_a: assert property ($rose(ctl_oe) |-> $past(own_oe))
    else $error("controls driven before master indicator");
  own_trail_a: assert property ($fell(own_oe) |-> !$past(ctl_oe))
    else $error("master indicator released before controls");
  buf_idle_a: assert property (tc |-> !buffer_direction &&
    buffer_enable_strobe_n) else $error("buffer lines active in single");
  dtc_hold_a: assert property (tc |-> ds ##1 !ds)
    else $error("data strobes not held past complete strobe");
  dtc_pulse_a: assert property ($rose(tc) |=> !tc)
    else $error("complete strobe longer than one cycle");
  dtc_grant_a: assert property (tc |-> gnt)
    else $error("complete strobe without grant strobe");
  ds_grant_a: assert property ($rose(ds) && !rw && gnt |->
    $past(gnt, 2) && !$past(gnt, 3))
    else $error("strobe not 1 clk after grant");
  mux_addr_a: assert property ($fell(as_n) && gnt |->
    ctrl_ad_oe [*3] ##1 !ctrl_ad_oe) else $error("address phase length wrong");
  m2d_len_a: assert property ($fell(as_n) && gnt |-> ##6 tc)
    else $error("memory to device cycle length wrong");
  d2m_len_a: assert property ($rose(tc) && !rw |->
    $past(as_n, 9) && !$past(as_n, 8))
    else $error("device to memory length wrong");
endmodule : dmadtp_props

// ==== tb.sv ====
// Self-checking bench joining the controller and the system end.
`timescale 1ns/1ns
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] dev_rd_data, dev_wr_data, peek_data;
  logic        dev_wr_stb, err;
  logic [4:0]  peek_addr;
  logic [15:0] got[$];
  int          bad_count, cmp_count;
  dmadtp_if bus_if ();
  dmadtp_ctrl dmadtp_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus_if));
  dmadtp_sys dmadtp_sys_inst (.pclk(pclk), .presetn(presetn), .bus(bus_if),
    .dev_rd_data(dev_rd_data), .dev_wr_data(dev_wr_data),
    .dev_wr_stb(dev_wr_stb), .peek_addr(peek_addr), .peek_data(peek_data));
  dmadtp_props props_inst (.pclk(pclk), .presetn(presetn),
    .own_oe(bus_if.own_oe), .ctl_oe(bus_if.ctl_oe), .as_n(bus_if.as_n),
    .uds_n(bus_if.uds_n), .lds_n(bus_if.lds_n), .rw(bus_if.rw),
    .ctrl_ad_oe(bus_if.ctrl_ad_oe), .grant_strobe_n(bus_if.grant_strobe_n),
    .transfer_complete_strobe_n(bus_if.transfer_complete_strobe_n),
    .buffer_direction(bus_if.buffer_direction),
    .buffer_enable_strobe_n(bus_if.buffer_enable_strobe_n));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Deliveries are one-cycle pulses, so they are gathered as they come.
  always @(posedge pclk) begin
    if (dev_wr_stb === 1'b1) got.push_back(dev_wr_data);
  end

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic start(input logic [1:0] c, input logic [9:0] f,
                       input logic [23:0] m, input logic [23:0] d);
    got.delete();
    apb(1'b1, {2'h0, c, 4'h0}, {22'h0, f});
    apb(1'b1, {2'h0, c, 4'h4}, {8'h0, m});
    apb(1'b1, {2'h0, c, 4'h8}, {8'h0, d});
    apb(1'b1, dmadtp_pkg::OFS_CMD, {29'h0, c, 1'b1});
  endtask : start
  task automatic finish_op(input logic [1:0] c, input logic [23:0] m,
                           input logic [23:0] d);
    int n;
    n = 0;
    rd = 32'h0;
    while (rd[1] !== 1'b1 && n < 400) begin
      apb(1'b0, dmadtp_pkg::OFS_STAT, 32'h0);
      n++;
    end
    chk("status", {28'h0, c, 2'h2}, rd);
    apb(1'b0, {2'h0, c, 4'h4}, 32'h0);
    chk("mem ptr", {8'h0, m}, rd);
    apb(1'b0, {2'h0, c, 4'h8}, 32'h0);
    chk("dev ptr", {8'h0, d}, rd);
  endtask : finish_op
  task automatic peek(input logic [4:0] a, input logic [15:0] e);
    peek_addr <= a;
    repeat (2) @(posedge pclk);
    chk("memory word", {16'h0, e}, {16'h0, peek_data});
  endtask : peek

  task automatic t_reset;
    apb(1'b0, 8'h00, 32'h0);
    chk("cfg reset", {22'h0, dmadtp_pkg::CFG_RST}, rd);
    apb(1'b0, 8'h4c, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
  endtask : t_reset
  // Word from a 16-bit acknowledge device into memory, memory counting up.
  task automatic t_single_in;
    dev_rd_data <= 16'hbeef;
    start(2'h1, 10'h06e, 24'h000010, 24'h800000);
    finish_op(2'h1, 24'h000012, 24'h800000);
    peek(5'h08, 16'hbeef);
  endtask : t_single_in
  task automatic t_single_out;
    start(2'h2, 10'h08f, 24'h000010, 24'h800000);
    finish_op(2'h2, 24'h00000e, 24'h800000);
    chk("delivered", 32'h1, got.size());
    if (got.size() > 0) chk("word out", 32'hbeef, {16'h0, got[0]});
  endtask : t_single_out
  // Word from a byte-port native device: two parts, high byte first.
  task automatic t_dual_in;
    dev_rd_data <= 16'h005a;
    start(2'h0, 10'h168, 24'h000012, 24'h800100);
    finish_op(2'h0, 24'h000014, 24'h800104);
    peek(5'h09, 16'h5a5a);
  endtask : t_dual_in
  task automatic t_eclk_long;
    logic [7:0] e[4];
    e = '{8'hbe, 8'hef, 8'h5a, 8'h5a};
    start(2'h3, 10'h251, 24'h000010, 24'h800108);
    finish_op(2'h3, 24'h000014, 24'h800100);
    chk("byte parts", 32'h4, got.size());
    for (int i = 0; i < 4 && i < got.size(); i++) begin
      chk("byte out", {24'h0, e[i]}, {24'h0, got[i][7:0]});
    end
    apb(1'b0, 8'h10, 32'h0);
    chk("channel cfg kept", 32'h06e, rd);
  endtask : t_eclk_long
  task automatic t_eclk_in;
    dev_rd_data <= 16'h0033;
    start(2'h0, 10'h061, 24'h000015, 24'h800100);
    finish_op(2'h0, 24'h000016, 24'h800100);
    peek(5'h0a, 16'h0033);
  endtask : t_eclk_in

  initial begin
    #400000;
    bad_count++;
    conclude();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {dev_rd_data, peek_addr, bad_count, cmp_count} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_single_in();
    t_single_out();
    t_dual_in();
    t_eclk_long();
    t_eclk_in();
    conclude();
  end
endmodule : tb
